// *** dbac_pkg.sv ***
// Constants and types for the debug bus attribute control word
package dbac_pkg;

  // Bus variant served by one build of the block
  typedef enum logic [1:0] {
    DBAC_AXI5,
    DBAC_AHB3,
    DBAC_AHB5
  } dbac_variant_t;

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] WORD_ADDR = 8'h00;

  // Field positions in the control word
  localparam int PROT_HI = 30;
  localparam int PROT_LO = 24;
  localparam int SPD_BIT = 23;
  localparam int TAG_BIT = 15;
  localparam int DOM_HI = 14;
  localparam int DOM_LO = 13;
  localparam int PEND_BIT = 7;
  localparam int DEN_BIT = 6;
  localparam int INC_HI = 5;
  localparam int INC_LO = 4;
  localparam int SIZE_HI = 2;
  localparam int SIZE_LO = 0;

  // Positions inside the seven-bit protection field
  localparam int P_TOP = 6;
  localparam int P_MID = 5;
  localparam int P_ALLOC = 4;
  localparam int P_CACHE = 3;
  localparam int P_BUF = 2;

  // Reset values
  localparam logic [6:0] PROT_RST_AXI = 7'h30;
  localparam logic [6:0] PROT_RST_AHB = 7'h43;
  localparam logic [3:0] HPROT_LOW_FIXED = 4'h3;
  localparam logic [1:0] DOMAIN_RST = 2'h3;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [1:0] INC_OFF = 2'h0;
  localparam logic [1:0] INC_PACKED = 2'h2;
  localparam logic [1:0] INC_RSVD = 2'h3;

  // Requester identities (values are arbitrary)
  localparam logic [3:0] OWN_ID_DEF = 4'h1;
  localparam logic [3:0] ALT_ID_DEF = 4'h2;

  // Attributes driven toward the system bus
  typedef struct packed {
    logic [2:0] axi_prot;
    logic [3:0] axi_cache;
    logic [1:0] axi_domain;
    logic [6:0] hprot;
    logic hnonsec;
    logic [3:0] hmaster;
    logic tag_access_enable;
    logic [2:0] size;
    logic [1:0] address_step_mode;
  } dbac_attr_t;

endpackage : dbac_pkg

// *** dbac_ctrl.sv ***
// Control/status word and bus attribute logic of a memory access port
// Summary of operation
// - AXI5: word bits 30,29,28 drive protection bits 2,1,0.
// - Non-secure bit set drives protection bit 1 high on the channel.
// - AXI5: secure request needs permit; without it no transfer, error returned.
// - AXI5: word bits 27:24 drive cache attribute bits 3:0 in order.
// - AXI5: protection and cache field resets to 0110000.
// - AXI5: bit 23 reads the synchronised secure-debug permit level.
// - Bit 15 enables tag transfers; reads zero when tagging is absent.
// - Bits 14:13 drive domain; reset to system (11).
// - Size field supports byte, half-word, word; larger sizes optional.
// - AHB3: bit 30 drives non-secure, resets 1; absent reads one.
// - Bit 29 selects own or second requester identity on the master id.
// - AHB3: bit 28 drives allocate; absent reads zero, ignores writes.
// - AHB3: bits 27:24 drive protection 3:0; absent reads 0011 fixed.
// - AHB3: protection field resets to 1000011.
// - AHB3: bit 23 read-only, mirrors permit optionally, else zero.
// - AHB5: bit 27 drives prot 6,4,3; 26:24 drive 2:0; 5 low.
// - AHB5: secure-debug bit read-only, zero when unsupported.
// - Pending bit reads one while a transfer is outstanding.
// - Enable bit mirrors the enable input; zero blocks transfers.
// - AHB5: bit 30 optionally drives non-secure, resets to one.
// - Packed increment required for AXI5, optional for AHB.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module dbac_ctrl #(
  parameter dbac_pkg::dbac_variant_t VARIANT = dbac_pkg::DBAC_AXI5,
  parameter bit HAS_TAG = 1'b0,
  parameter bit HAS_HNONSEC = 1'b1,
  parameter bit HAS_REQ_SEL = 1'b1,
  parameter bit HAS_ALLOC = 1'b1,
  parameter bit HAS_HPROT_LOW = 1'b1,
  parameter bit MIRROR_SPD = 1'b1,
  parameter bit HAS_DEV_EN = 1'b1,
  parameter bit HAS_PACKED = 1'b1,
  parameter logic [2:0] MAX_SIZE = dbac_pkg::SIZE_WORD,
  parameter logic [3:0] OWN_ID = dbac_pkg::OWN_ID_DEF,
  parameter logic [3:0] ALT_ID = dbac_pkg::ALT_ID_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [dbac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Authentication and enable pins
  input wire logic secure_debug_permit,
  input wire logic target_enable_input,
  // Transfer requests from the data register logic
  input wire logic xfer_req,
  input wire logic xfer_done,
  output logic xfer_go,
  output logic xfer_err,
  // Attributes toward the system bus
  output dbac_pkg::dbac_attr_t bus_attr
);

  localparam bit IS_AXI = (VARIANT == dbac_pkg::DBAC_AXI5);
  localparam bit IS_AHB3 = (VARIANT == dbac_pkg::DBAC_AHB3);
  localparam bit IS_AHB5 = (VARIANT == dbac_pkg::DBAC_AHB5);

  typedef struct packed {
    logic [6:0] prot;
    logic tag_en;
    logic [1:0] domain;
    logic [1:0] addr_inc;
    logic [2:0] size;
    logic pending;
    logic go;
    logic err;
    logic [2:0] spd_sync;
    logic [2:0] den_sync;
    logic spd;
    logic den;
    logic [31:0] rdata;
  } dbac_state_t;

  // Forces unsupported protection bits to their fixed read values
  function automatic logic [6:0] fix_prot(input logic [6:0] w);
    logic [6:0] p;
    p = w;
    if (IS_AHB3)
    begin
      if (!HAS_HNONSEC)
      begin
        p[dbac_pkg::P_TOP] = 1'b1;
      end
      if (!HAS_REQ_SEL)
      begin
        p[dbac_pkg::P_MID] = 1'b0;
      end
      if (!HAS_ALLOC)
      begin
        p[dbac_pkg::P_ALLOC] = 1'b0;
      end
      if (!HAS_HPROT_LOW)
      begin
        p[dbac_pkg::P_CACHE:0] = dbac_pkg::HPROT_LOW_FIXED;
      end
    end
    else if (IS_AHB5)
    begin
      if (!HAS_HNONSEC)
      begin
        p[dbac_pkg::P_TOP] = 1'b0;
      end
      if (!HAS_REQ_SEL)
      begin
        p[dbac_pkg::P_MID] = 1'b0;
      end
      p[dbac_pkg::P_ALLOC] = 1'b0;
    end
    return p;
  endfunction : fix_prot

  // AXI5 and AHB reset patterns differ; AHB5 takes the AHB pattern
  localparam logic [6:0] PROT_RST = IS_AXI ? dbac_pkg::PROT_RST_AXI
                                           : fix_prot(dbac_pkg::PROT_RST_AHB);

  localparam dbac_state_t RST_STATE = '{
    prot: PROT_RST,
    tag_en: 1'b0,
    domain: dbac_pkg::DOMAIN_RST,
    addr_inc: dbac_pkg::INC_OFF,
    size: dbac_pkg::SIZE_WORD,
    pending: 1'b0,
    go: 1'b0,
    err: 1'b0,
    spd_sync: 3'h0,
    den_sync: 3'h0,
    spd: 1'b0,
    den: 1'b0,
    rdata: 32'h0
  };

  dbac_state_t state_r;
  dbac_state_t state_nxt;

  logic den_eff;
  logic spd_read;
  logic permit;
  logic hit;
  logic size_ok;
  logic inc_ok;
  logic [2:0] w_size;
  logic [1:0] w_inc;
  logic [31:0] word;

  always_comb
  begin
    state_nxt = state_r;
    w_size = reg_wdata[dbac_pkg::SIZE_HI:dbac_pkg::SIZE_LO];
    w_inc = reg_wdata[dbac_pkg::INC_HI:dbac_pkg::INC_LO];
    hit = (reg_addr == dbac_pkg::WORD_ADDR);

    // Pins pass three flops; a level is taken once stages two and three agree
    state_nxt.spd_sync = {state_r.spd_sync[1:0], secure_debug_permit};
    state_nxt.den_sync = {state_r.den_sync[1:0], target_enable_input};
    if (state_r.spd_sync[2] == state_r.spd_sync[1])
    begin
      state_nxt.spd = state_r.spd_sync[2];
    end
    if (state_r.den_sync[2] == state_r.den_sync[1])
    begin
      state_nxt.den = state_r.den_sync[2];
    end

    den_eff = HAS_DEV_EN ? state_r.den : 1'b1;
    if (IS_AXI)
    begin
      spd_read = state_r.spd;
    end
    else
    begin
      spd_read = MIRROR_SPD & state_r.spd;
    end

    // Only AXI5 refuses on the security attribute; on AHB, hnonsec never blocks a transfer
    permit = den_eff & (~IS_AXI | state_r.prot[dbac_pkg::P_MID] | state_r.spd);
    state_nxt.go = xfer_req & permit;
    state_nxt.err = xfer_req & ~permit;
    // A completion in the issue cycle must not hide the new transfer
    state_nxt.pending = state_nxt.go | (state_r.pending & ~xfer_done);

    // Unsupported size or step codes are ignored so the field stays legal
    size_ok = (w_size <= dbac_pkg::SIZE_WORD) | (IS_AXI & (w_size <= MAX_SIZE));
    inc_ok = (w_inc != dbac_pkg::INC_RSVD) &
             ((w_inc != dbac_pkg::INC_PACKED) | IS_AXI | HAS_PACKED);

    if (reg_wr && hit)
    begin
      state_nxt.prot = fix_prot(reg_wdata[dbac_pkg::PROT_HI:dbac_pkg::PROT_LO]);
      if (IS_AXI)
      begin
        state_nxt.tag_en = HAS_TAG & reg_wdata[dbac_pkg::TAG_BIT];
        state_nxt.domain = reg_wdata[dbac_pkg::DOM_HI:dbac_pkg::DOM_LO];
      end
      if (size_ok)
      begin
        state_nxt.size = w_size;
      end
      if (inc_ok)
      begin
        state_nxt.addr_inc = w_inc;
      end
    end

    // Read value; every bit not set below is reserved and reads zero
    word = 32'h0;
    word[dbac_pkg::PROT_HI:dbac_pkg::PROT_LO] = state_r.prot;
    word[dbac_pkg::SPD_BIT] = spd_read;
    if (IS_AXI)
    begin
      word[dbac_pkg::TAG_BIT] = state_r.tag_en;
      word[dbac_pkg::DOM_HI:dbac_pkg::DOM_LO] = state_r.domain;
    end
    word[dbac_pkg::PEND_BIT] = state_r.pending;
    word[dbac_pkg::DEN_BIT] = den_eff;
    word[dbac_pkg::INC_HI:dbac_pkg::INC_LO] = state_r.addr_inc;
    word[dbac_pkg::SIZE_HI:dbac_pkg::SIZE_LO] = state_r.size;
    // Read data stands for exactly one cycle and is zero otherwise
    state_nxt.rdata = (reg_rd && hit) ? word : 32'h0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= RST_STATE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Attribute mapping toward the bus
  always_comb
  begin
    bus_attr = '0;
    bus_attr.axi_prot = state_r.prot[dbac_pkg::P_TOP:dbac_pkg::P_ALLOC];
    bus_attr.axi_cache = state_r.prot[dbac_pkg::P_CACHE:0];
    bus_attr.axi_domain = state_r.domain;
    bus_attr.tag_access_enable = state_r.tag_en;
    bus_attr.size = state_r.size;
    bus_attr.address_step_mode = state_r.addr_inc;
    bus_attr.hnonsec = state_r.prot[dbac_pkg::P_TOP];
    if (IS_AHB5 && !HAS_HNONSEC)
    begin
      // No control bit: keep the bus on the harmless non-secure side
      bus_attr.hnonsec = 1'b1;
    end
    if (HAS_REQ_SEL && !state_r.prot[dbac_pkg::P_MID])
    begin
      bus_attr.hmaster = ALT_ID;
    end
    else
    begin
      bus_attr.hmaster = OWN_ID;
    end
    if (IS_AHB3)
    begin
      bus_attr.hprot = {2'h0, state_r.prot[dbac_pkg::P_ALLOC:0]};
    end
    else if (IS_AHB5)
    begin
      bus_attr.hprot = {state_r.prot[dbac_pkg::P_CACHE], 1'b0,
                        state_r.prot[dbac_pkg::P_CACHE], state_r.prot[dbac_pkg::P_CACHE],
                        state_r.prot[dbac_pkg::P_BUF:0]};
    end
  end

  assign reg_rdata = state_r.rdata;
  assign xfer_go = state_r.go;
  assign xfer_err = state_r.err;

endmodule : dbac_ctrl

`default_nettype wire

// *** dbac_ctrl_checker.sv ***
// Assertion checker for the control word block
`timescale 1ns/1ps
`default_nettype none
module dbac_ctrl_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [dbac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins and transfer port
  input wire logic secure_debug_permit,
  input wire logic target_enable_input,
  input wire logic xfer_req,
  input wire logic xfer_done,
  input wire logic xfer_go,
  input wire logic xfer_err,
  input wire dbac_pkg::dbac_attr_t bus_attr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = reg_wr && reg_addr == dbac_pkg::WORD_ADDR;
  assign ctl_rd = reg_rd && reg_addr == dbac_pkg::WORD_ADDR;
  // Pins cross a synchroniser, so a level counts only after six edges
  sequence en_high; target_enable_input [*6]; endsequence
  sequence en_low; !target_enable_input [*6]; endsequence
  sequence permit_low; !secure_debug_permit [*6]; endsequence
  sequence done_then_rd; xfer_done ##1 (!xfer_go && ctl_rd); endsequence
  prot_write_a: assert property (ctl_wr |=>
    {bus_attr.axi_prot, bus_attr.axi_cache} == $past(reg_wdata[30:24]))
    else $error("protection attributes differ from written word");
  domain_write_a: assert property (ctl_wr |=>
    bus_attr.axi_domain == $past(reg_wdata[14:13]))
    else $error("domain attribute differs from written word");
  reset_attr_a: assert property ($rose(rst_n) |-> bus_attr.axi_domain == 2'h3
    && {bus_attr.axi_prot, bus_attr.axi_cache} == 7'h30)
    else $error("attributes wrong after reset");
  rd_idle_a: assert property (!ctl_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a control word read");
  reserved_zero_a: assert property ((reg_rdata & 32'h807f_1f08) == 32'h0)
    else $error("reserved bit read as one");
  one_answer_a: assert property (xfer_req |=> xfer_go ^ xfer_err)
    else $error("request not answered by exactly one of go and error");
  ns_go_a: assert property (en_high ##0 (xfer_req && bus_attr.axi_prot[1]) |=> xfer_go)
    else $error("non-secure request refused");
  secure_block_a: assert property (permit_low ##0 (xfer_req && !bus_attr.axi_prot[1])
    |=> xfer_err) else $error("secure request issued without permit");
  disabled_block_a: assert property (en_low ##0 xfer_req |=> !xfer_go)
    else $error("transfer issued while disabled");
  pend_set_a: assert property (xfer_go && ctl_rd |=> reg_rdata[dbac_pkg::PEND_BIT])
    else $error("pending bit low while transfer issued");
  pend_clear_a: assert property (done_then_rd |=> !reg_rdata[dbac_pkg::PEND_BIT])
    else $error("pending bit high after completion");
endmodule : dbac_ctrl_checker
bind dbac_ctrl dbac_ctrl_checker i_dbac_ctrl_checker (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .secure_debug_permit(secure_debug_permit),
  .target_enable_input(target_enable_input), .xfer_req(xfer_req), .xfer_done(xfer_done),
  .xfer_go(xfer_go), .xfer_err(xfer_err), .bus_attr(bus_attr));
`default_nettype wire

// *** dbac_bus_model.sv ***
// Behavioural system bus that completes issued transfers
`timescale 1ns/1ps
`default_nettype none
module dbac_bus_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Transfer handshake
  input wire logic xfer_go,
  input wire logic slow,
  output logic xfer_done
);
  logic [3:0] wait_r;
  // One transfer in flight; a second go restarts the count
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r <= 4'h0;
      xfer_done <= 1'b0;
    end
    else
    begin
      xfer_done <= wait_r == 4'h1;
      if (xfer_go)
        wait_r <= slow ? 4'h9 : 4'h2;
      else if (wait_r != 4'h0)
        wait_r <= wait_r - 4'h1;
    end
  end
endmodule : dbac_bus_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the control word block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, rst_n, reg_wr, reg_rd, permit, enable, xfer_req, xfer_done, xfer_go, xfer_err;
  logic slow, go, m_tag;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, q;
  logic [6:0] m_prot;
  logic [1:0] m_dom, m_inc;
  logic [2:0] m_size;
  dbac_pkg::dbac_attr_t bus_attr;
  int n_fail, compares, k;
  dbac_ctrl #(.HAS_TAG(1'b1)) i_dbac_ctrl (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .secure_debug_permit(permit), .target_enable_input(enable), .xfer_req(xfer_req),
    .xfer_done(xfer_done), .xfer_go(xfer_go), .xfer_err(xfer_err), .bus_attr(bus_attr));
  dbac_bus_model i_dbac_bus_model (.clock(clock), .rst_n(rst_n), .xfer_go(xfer_go),
    .slow(slow), .xfer_done(xfer_done));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // Unsupported size and increment codes leave the old field in place
  task automatic upd(input logic [31:0] v);
    m_prot = v[30:24];
    m_tag = v[15];
    m_dom = v[14:13];
    if (v[5:4] != 2'h3) m_inc = v[5:4];
    if (v[2:0] <= 3'h2) m_size = v[2:0];
  endtask : upd
  function automatic logic [31:0] exp_word(input logic pend);
    return {1'b0, m_prot, permit, 7'h0, m_tag, m_dom, 5'h0, pend, enable, m_inc, 1'b0, m_size};
  endfunction : exp_word
  function automatic dbac_pkg::dbac_attr_t exp_attr();
    return {m_prot[6:4], m_prot[3:0], m_dom, 7'h0, m_prot[6],
      m_prot[5] ? dbac_pkg::OWN_ID_DEF : dbac_pkg::ALT_ID_DEF, m_tag, m_size, m_inc};
  endfunction : exp_attr
  initial
  begin
    #300000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, xfer_req, slow, reg_addr, reg_wdata} = '0;
    {permit, enable} = 2'b11;
    {m_prot, m_dom, m_tag, m_size, m_inc} = {7'h30, 2'h3, 1'b0, 3'h2, 2'h0};
    void'($urandom(45));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    rd(8'h00, q);
    chk(q, exp_word(1'b0));
    for (int i = 0; i < 40; i++)
    begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff_ffff : $urandom;
      wr(8'h00, d);
      upd(d);
      wr(8'h10 + 8'(i), ~d);
      #1 chk(32'(bus_attr), 32'(exp_attr()));
      rd(8'h10 + 8'(i), q);
      chk(q, 32'h0);
      rd(8'h00, q);
      chk(q, exp_word(1'b0));
    end
    for (int i = 0; i < 8; i++)
    begin
      d = exp_word(1'b0);
      d[29] = i[0];
      wr(8'h00, d);
      upd(d);
      {enable, permit, slow} <= 3'(i);
      repeat (6) @(posedge clock);
      go = i[2] && (i[0] || i[1]);
      xfer_req <= 1'b1;
      @(posedge clock);
      xfer_req <= 1'b0;
      reg_rd <= 1'b1;
      #1 chk(32'({xfer_go, xfer_err}), 32'({go, !go}));
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp_word(go));
      k = 0;
      while (go && !xfer_done && k < 20)
      begin
        @(posedge clock);
        #1 k++;
      end
      if (k == 20)
      begin
        n_fail++;
        tally_and_finish();
      end
      rd(8'h00, q);
      chk(32'(q[7]), 32'h0);
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
